// ==== src/ecc_consts.svh ====
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH

// ============================================================
// Register address and reset value
`define ECC_ADDR_EN        8'h07
`define ECC_EN_RESET       16'h0040
`define ECC_EN_WMASK       16'h1fff

// ============================================================
// Bit positions inside the enable register
`define ECC_B_NEG_INPUT    10
`define ECC_B_REF_RANGE    9
`define ECC_B_REF_DETECT   8
`define ECC_B_CONV         7
`define ECC_B_IGNORE       6
`define ECC_B_CLK_COUNT    5
`define ECC_B_RD_ADDR      4
`define ECC_B_WR_ADDR      3
`define ECC_B_CHECKSUM     2

// Number of flags handled by this block
`define ECC_NFLAG          9

`endif

// ==== src/ecc_pkg.sv ====
package ecc_pkg;
	// Index of each flag inside the flag vector
	typedef enum logic [3:0] {
		ECC_F_CHECKSUM,
		ECC_F_WR_ADDR,
		ECC_F_RD_ADDR,
		ECC_F_CLK_COUNT,
		ECC_F_IGNORE,
		ECC_F_CONV,
		ECC_F_REF_DETECT,
		ECC_F_REF_RANGE,
		ECC_F_NEG_INPUT
	} ecc_flag_t;

	// Host access phase
	typedef enum logic [1:0] {
		ECC_IDLE,
		ECC_WRITE,
		ECC_READ
	} ecc_acc_t;
endpackage

// ==== src/ecc_flag_if.sv ====
`timescale 1ns/10ps
// Flag bank handshake: raw events in, gated sticky flags out
interface ecc_flag_if #(parameter int N = 9);
	logic [N-1:0] gate;
	logic [N-1:0] event_raw;
	logic [N-1:0] clear;
	logic [N-1:0] flags;
	modport bank (input gate, input event_raw, input clear, output flags);
	modport ctrl (output gate, output event_raw, output clear, input flags);
endinterface

// ==== src/ecc_flag_bank.sv ====
`timescale 1ns/10ps
`include "ecc_consts.svh"

// ============================================================
// Sticky flag bank
module ecc_flag_bank #(
	parameter int N = `ECC_NFLAG
) (
	input  wire logic  clk_i,
	input  wire logic  nrst_i,
	ecc_flag_if.bank   fl
);
	typedef struct packed {
		logic [N-1:0] flags;
	} ecc_bank_st_t;

	ecc_bank_st_t st_q;
	ecc_bank_st_t st_d;

	// An empty bank has nothing to hold; refuse it while elaborating
	if (N < 1) begin : g_n_check
		$error("ecc_flag_bank: N must be positive");
	end

	// Set wins over clear so a same-cycle event is never lost
	always_comb begin
		st_d = st_q;
		st_d.flags = (st_q.flags & ~fl.clear) | (fl.event_raw & fl.gate);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign fl.flags = st_q.flags;

	// No flag may rise at an edge where its own gate was off
	a_gate_holds_off: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(st_q.flags & ~$past(st_q.flags) & ~$past(fl.gate)) == '0)
		else $error("flag raised while its check was off");

	// Zero in the clear vector keeps every set flag
	a_flag_sticky: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(~st_q.flags & $past(st_q.flags) & ~$past(fl.clear)) == '0)
		else $error("flag dropped without a clear");
endmodule

// ==== src/ecc_error_enable.sv ====
`timescale 1ns/10ps
`include "ecc_consts.svh"

// Function
// - Bit 10 gates the negative input range flag; resets to zero.
// - Bit 9 gates the reference range error flag.
// - Bit 8 gates the missing reference flag.
// - Bit 7 gates the conversion and calibration fault flag.
// - Bit 6 enables the ignored-write check and resets to one.
// - Ignored-write error if host writes during fuse copy.
// - Ignored-write error if host writes during offset or gain calibration.
// - Bit 5 gates the serial clock count error flag; resets zero.
// - Bit 4 read check works only with chip select use also on.
// - Read of a nonexistent address sets the read error flag.
// - Bit 3 write check works only with chip select use also on.
// - Write to undefined or read-only address sets write error flag.
// - Bit 2 enables checksum check of written and read data.
// - Each of bits 2 to 10 maps to exactly one error flag.
module ecc_error_enable #(
	parameter int AW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	input  wire ecc_pkg::ecc_acc_t acc_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [15:0]   wdata_i,
	input  wire logic          addr_valid_i,
	input  wire logic          addr_ro_i,
	input  wire logic          chip_select_use_on_i,
	input  wire logic          fuse_copy_i,
	input  wire logic          calib_busy_i,
	input  wire logic          neg_input_fault_i,
	input  wire logic          ref_range_fault_i,
	input  wire logic          ref_missing_i,
	input  wire logic          conv_fault_i,
	input  wire logic          clk_count_fault_i,
	input  wire logic          checksum_fault_i,
	input  wire logic [8:0]    flag_clear_i,
	output logic [15:0]        rdata_o,
	output logic [8:0]         flags_o,
	output logic               checksum_on_o,
	output logic               wr_ignored_o
);
	import ecc_pkg::*;

	// ============================================================
	// State
	typedef struct packed {
		logic [15:0] en;
		logic [15:0] rdata;
		logic [8:0]  flags;
		logic        checksum_on;
		logic        wr_ignored;
	} ecc_top_st_t;

	ecc_top_st_t st_q;
	ecc_top_st_t st_d;

	ecc_flag_if #(.N(`ECC_NFLAG)) fl ();

	// The decode compares eight address bits, so narrower buses cannot work
	if (AW < 8) begin : g_aw_check
		$error("ecc_error_enable: AW must be at least 8");
	end

	// Selects one enable bit; used for every gate below
	function automatic logic en_bit(input logic [15:0] r, input int b);
		return r[b];
	endfunction

	logic is_en_addr;
	logic host_write;
	logic host_read;
	logic ignore_write;
	assign is_en_addr = (addr_i[7:0] == `ECC_ADDR_EN);
	assign host_write = (acc_i == ECC_WRITE);
	assign host_read  = (acc_i == ECC_READ);
	// Writes while the map is busy are dropped, not applied
	assign ignore_write = host_write && (fuse_copy_i || calib_busy_i);

	// ============================================================
	// Gate and raw event vectors for the flag bank
	always_comb begin
		fl.gate = '0;
		fl.event_raw = '0;
		fl.gate[ECC_F_NEG_INPUT]  = en_bit(st_q.en, `ECC_B_NEG_INPUT);
		fl.gate[ECC_F_REF_RANGE]  = en_bit(st_q.en, `ECC_B_REF_RANGE);
		fl.gate[ECC_F_REF_DETECT] = en_bit(st_q.en, `ECC_B_REF_DETECT);
		fl.gate[ECC_F_CONV]       = en_bit(st_q.en, `ECC_B_CONV);
		fl.gate[ECC_F_IGNORE]     = en_bit(st_q.en, `ECC_B_IGNORE);
		fl.gate[ECC_F_CLK_COUNT]  = en_bit(st_q.en, `ECC_B_CLK_COUNT);
		// Address checks need chip select use as well
		fl.gate[ECC_F_RD_ADDR] = en_bit(st_q.en, `ECC_B_RD_ADDR)
			&& chip_select_use_on_i;
		fl.gate[ECC_F_WR_ADDR] = en_bit(st_q.en, `ECC_B_WR_ADDR)
			&& chip_select_use_on_i;
		fl.gate[ECC_F_CHECKSUM] = en_bit(st_q.en, `ECC_B_CHECKSUM);
		fl.event_raw[ECC_F_NEG_INPUT]  = neg_input_fault_i;
		fl.event_raw[ECC_F_REF_RANGE]  = ref_range_fault_i;
		fl.event_raw[ECC_F_REF_DETECT] = ref_missing_i;
		fl.event_raw[ECC_F_CONV]       = conv_fault_i;
		fl.event_raw[ECC_F_IGNORE]     = ignore_write;
		fl.event_raw[ECC_F_CLK_COUNT]  = clk_count_fault_i;
		fl.event_raw[ECC_F_RD_ADDR]    = host_read && !addr_valid_i;
		fl.event_raw[ECC_F_WR_ADDR]    = host_write
			&& (!addr_valid_i || addr_ro_i);
		fl.event_raw[ECC_F_CHECKSUM]   = checksum_fault_i;
		fl.clear = flag_clear_i;
	end

	ecc_flag_bank #(.N(`ECC_NFLAG)) u_bank (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.fl     (fl.bank)
	);

	// ============================================================
	// Register write, read-back and output staging
	always_comb begin
		st_d = st_q;
		if (host_write && is_en_addr && !ignore_write) begin
			st_d.en = wdata_i & `ECC_EN_WMASK;
		end
		if (host_read && is_en_addr) begin
			st_d.rdata = st_q.en;
		end else if (host_read) begin
			st_d.rdata = '0;
		end
		st_d.flags = fl.flags;
		st_d.checksum_on = en_bit(st_q.en, `ECC_B_CHECKSUM);
		st_d.wr_ignored = ignore_write;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '{en: `ECC_EN_RESET, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o = st_q.rdata;
	assign flags_o = st_q.flags;
	assign checksum_on_o = st_q.checksum_on;
	assign wr_ignored_o = st_q.wr_ignored;

	// ============================================================
	// Checks
	// Flags reach the pins two edges after the event, hence |=> ##1
	a_en_readback: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && is_en_addr && !ignore_write)
		##1 (host_read && is_en_addr)
		|=> rdata_o == ($past(wdata_i, 2) & `ECC_EN_WMASK))
		else $error("enable read-back differs from last write");

	// Reserved upper bits can never hold a one
	a_en_reserved: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		st_q.en[15:13] == 3'h0)
		else $error("reserved enable bits set");

	a_busy_write_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && calib_busy_i && st_q.en[`ECC_B_IGNORE])
		|=> ##1 flags_o[ECC_F_IGNORE])
		else $error("write during calibration not flagged");

	a_fuse_write_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && fuse_copy_i && st_q.en[`ECC_B_IGNORE])
		|=> ##1 flags_o[ECC_F_IGNORE])
		else $error("write during fuse copy not flagged");

	// A dropped write must leave the enables exactly as they were
	a_ign_keeps_en: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && is_en_addr && ignore_write) |=> $stable(st_q.en))
		else $error("dropped write changed the enables");

	a_ign_pulse: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ignore_write |=> wr_ignored_o)
		else $error("dropped write not reported");

	a_rd_needs_cs: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(!chip_select_use_on_i && !fl.flags[ECC_F_RD_ADDR])
		|=> !fl.flags[ECC_F_RD_ADDR])
		else $error("read check ran without chip select use");

	a_rd_bad_addr: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_read && !addr_valid_i && chip_select_use_on_i
		&& st_q.en[`ECC_B_RD_ADDR]) |=> ##1 flags_o[ECC_F_RD_ADDR])
		else $error("invalid read not flagged");

	a_wr_bad_addr: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && addr_ro_i && chip_select_use_on_i
		&& st_q.en[`ECC_B_WR_ADDR]) |=> ##1 flags_o[ECC_F_WR_ADDR])
		else $error("write to read-only address not flagged");

	a_wr_bad_invalid: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(host_write && !addr_valid_i && chip_select_use_on_i
		&& st_q.en[`ECC_B_WR_ADDR]) |=> ##1 flags_o[ECC_F_WR_ADDR])
		else $error("write to undefined address not flagged");

	a_neg_off_quiet: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(!st_q.en[`ECC_B_NEG_INPUT] && !fl.flags[ECC_F_NEG_INPUT])
		|=> !fl.flags[ECC_F_NEG_INPUT])
		else $error("negative input flag set while disabled");

	a_clk_off_quiet: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(!st_q.en[`ECC_B_CLK_COUNT] && !fl.flags[ECC_F_CLK_COUNT])
		|=> !fl.flags[ECC_F_CLK_COUNT])
		else $error("clock count flag set while disabled");

	// One fault at a time, as the host and the converter will see them
	a_ref_range_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(ref_range_fault_i && st_q.en[`ECC_B_REF_RANGE])
		|=> ##1 flags_o[ECC_F_REF_RANGE])
		else $error("enabled reference range fault not flagged");

	a_ref_detect_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(ref_missing_i && st_q.en[`ECC_B_REF_DETECT])
		|=> ##1 flags_o[ECC_F_REF_DETECT])
		else $error("enabled missing reference not flagged");

	a_conv_on_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(conv_fault_i && st_q.en[`ECC_B_CONV])
		|=> ##1 flags_o[ECC_F_CONV])
		else $error("enabled conversion fault not flagged");

	a_cks_fault_flag: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		(checksum_fault_i && st_q.en[`ECC_B_CHECKSUM])
		|=> ##1 flags_o[ECC_F_CHECKSUM])
		else $error("enabled checksum fault not flagged");

	a_cks_follow: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		st_q.en[`ECC_B_CHECKSUM] |=> checksum_on_o)
		else $error("checksum enable output does not follow its bit");
endmodule

// ==== sim/ecc_host_model.sv ====
`timescale 1ns/10ps
// ============================================================
// Host side of the register link
module ecc_host_model (
	input  wire logic  clk_i,
	output ecc_pkg::ecc_acc_t acc_o,
	output logic [7:0]  addr_o,
	output logic [15:0] wdata_o
);
	import ecc_pkg::*;

	// Idle from time zero so nothing is taken during reset
	initial begin
		acc_o   = ECC_IDLE;
		addr_o  = 8'h00;
		wdata_o = 16'h0000;
	end

	// One access per call, started on a rising edge; released address and
	// data are inverted so a stale value can never look like a fresh request
	task automatic access(input ecc_acc_t a, input logic [7:0] ad,
		input logic [15:0] d);
		acc_o   <= a;
		addr_o  <= ad;
		wdata_o <= d;
		@(posedge clk_i);
		acc_o   <= ECC_IDLE;
		addr_o  <= ~ad;
		wdata_o <= ~d;
	endtask

	// Write, then read the same address at the very next edge
	task automatic wr_rd(input logic [7:0] ad, input logic [15:0] d);
		acc_o   <= ECC_WRITE;
		addr_o  <= ad;
		wdata_o <= d;
		@(posedge clk_i);
		acc_o   <= ECC_READ;
		@(posedge clk_i);
		acc_o   <= ECC_IDLE;
		addr_o  <= ~ad;
		wdata_o <= ~d;
	endtask
endmodule

// ==== sim/error_check_enable_control_tb_top.sv ====
`timescale 1ns/10ps
// ============================================================
// Bench for the error check enable bank
module error_check_enable_control_tb_top;
	import ecc_pkg::*;
	logic        clk_i, nrst_i, cs_on, fuse, cal, cks_on, wr_ign;
	logic [5:0]  flt;
	logic [8:0]  clr, flags;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	ecc_acc_t    acc;
	int          failures, tests_run;

	ecc_host_model host (.clk_i(clk_i), .acc_o(acc), .addr_o(addr),
		.wdata_o(wdata));

	// Address decode lives outside the block; 0x08 stands for read-only
	ecc_error_enable dut (.clk_i(clk_i), .nrst_i(nrst_i), .acc_i(acc),
		.addr_i(addr), .wdata_i(wdata), .addr_valid_i(addr < 8'h19),
		.addr_ro_i(addr == 8'h08), .chip_select_use_on_i(cs_on),
		.fuse_copy_i(fuse), .calib_busy_i(cal),
		.neg_input_fault_i(flt[0]), .ref_range_fault_i(flt[1]),
		.ref_missing_i(flt[2]), .conv_fault_i(flt[3]),
		.clk_count_fault_i(flt[4]), .checksum_fault_i(flt[5]),
		.flag_clear_i(clr), .rdata_o(rdata), .flags_o(flags),
		.checksum_on_o(cks_on), .wr_ignored_o(wr_ign));

	// ============================================================
	// Shared tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] d);
		host.access(ECC_WRITE, 8'h07, d);
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [15:0] e);
		host.access(ECC_READ, 8'h07, 16'h0000);
		@(negedge clk_i);
		chk(rdata, e);
		@(posedge clk_i);
	endtask
	task automatic cks_chk(input logic e);
		@(negedge clk_i);
		chk({15'h0000, cks_on}, {15'h0000, e});
		@(posedge clk_i);
	endtask
	task automatic b2b_chk(input logic [15:0] d, input logic [15:0] e);
		host.wr_rd(8'h07, d);
		@(negedge clk_i);
		chk(rdata, e);
		@(posedge clk_i);
	endtask
	task automatic fl_chk(input logic [8:0] e);
		@(negedge clk_i);
		chk({7'h00, flags}, {7'h00, e});
		@(posedge clk_i);
	endtask
	// Flags lag their cause by two edges: bank flop, then output flop
	task automatic clr_all();
		clr <= 9'h1ff;
		@(posedge clk_i);
		clr <= 9'h000;
		@(posedge clk_i);
	endtask
	task automatic acc_fl(input ecc_acc_t a, input logic [7:0] ad,
		input logic [8:0] e);
		host.access(a, ad, 16'h0000);
		@(posedge clk_i);
		fl_chk(e);
		clr_all();
	endtask

	// ============================================================
	// Scenarios
	task automatic t_reset();
		rd_chk(16'h0040);
		cks_chk(1'b0);
		fl_chk(9'h000);
		$display("test reset done");
	endtask
	task automatic t_rw();
		wr(16'hffff);
		rd_chk(16'h1fff);
		cks_chk(1'b1);
		b2b_chk(16'he0c4, 16'h00c4);
		$display("test readback done");
	endtask
	task automatic t_gate();
		int fi[6] = '{8, 7, 6, 5, 3, 0};
		int eb[6] = '{10, 9, 8, 7, 5, 2};
		for (int i = 0; i < 6; i++) begin
			for (int on = 0; on < 2; on++) begin
				wr(16'h0040 | (16'(on) << eb[i]));
				flt <= 6'h01 << i;
				@(posedge clk_i);
				flt <= 6'h00;
				@(posedge clk_i);
				fl_chk(9'(on) << fi[i]);
				fl_chk(9'(on) << fi[i]);
				clr_all();
				fl_chk(9'h000);
			end
		end
		$display("test gating done");
	endtask
	// A dropped write must leave the enables alone and raise one pulse
	task automatic t_ignore();
		wr(16'h0040);
		for (int k = 0; k < 2; k++) begin
			fuse <= (k == 0);
			cal  <= (k == 1);
			host.access(ECC_WRITE, 8'h07, 16'h0000);
			@(negedge clk_i);
			chk({15'h0000, wr_ign}, 16'h0001);
			@(posedge clk_i);
			fuse <= 1'b0;
			cal  <= 1'b0;
			fl_chk(9'h010);
			clr_all();
			rd_chk(16'h0040);
		end
		$display("test ignored write done");
	endtask
	task automatic t_addr();
		wr(16'h0058);
		acc_fl(ECC_READ, 8'h30, 9'h000);
		acc_fl(ECC_WRITE, 8'h08, 9'h000);
		cs_on <= 1'b1;
		acc_fl(ECC_READ, 8'h30, 9'h004);
		acc_fl(ECC_WRITE, 8'h08, 9'h002);
		acc_fl(ECC_WRITE, 8'h30, 9'h002);
		$display("test address checks done");
	endtask

	// ============================================================
	// Clock, main sequence, watchdog and verdict
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic end_sim();
		$display("comparisons %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		{nrst_i, cs_on, fuse, cal, flt, clr} = '0;
		failures  = 0;
		tests_run = 0;
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_rw();
		t_gate();
		t_ignore();
		t_addr();
		end_sim();
	end
	// The run needs well under a thousand cycles
	initial begin
		#50us;
		failures++;
		end_sim();
	end
endmodule
